/* File: include/lpc_pkg.sv */
// Shared constants and types of the LVDS lane pattern checker.
// Assumes a 16-bit register port with byte addresses and four 13-lane LVDS banks.
`default_nettype none

package lpc_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_BANKS  = 4;
    localparam int FRAME_LEN  = 8;
    localparam int DATA_LANES = 12;
    localparam int SAMPLE_W   = 13;
    localparam int POS_W      = 3;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 12;
    localparam int REG_W      = 16;
    localparam int CREG_W     = 8;
    localparam int RSV_W      = 3;
    localparam int RD_PORTS   = NUM_BANKS + 1;

    // ==========================================================
    // Register map
    localparam logic [ADDR_W-1:0] ADDR_CFG       = 12'h710;
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h711;
    localparam logic [ADDR_W-1:0] ADDR_SUM       = 12'h712;
    localparam logic [ADDR_W-1:0] ADDR_PAT_BASE  = 12'h720;
    localparam logic [ADDR_W-1:0] PAT_SPAN       = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_STAT_BASE = 12'h750;
    localparam logic [ADDR_W-1:0] STAT_SPAN      = 12'h008;
    localparam int                WORD_SEL_LSB   = 1;

    // ==========================================================
    // Field positions and reset values
    localparam int CFG_EN_LSB    = 4;
    localparam int CFG_LOCK_BIT  = 1;
    localparam int CFG_CONT_BIT  = 0;
    localparam int CTRL_TRIG_BIT = 0;
    localparam int SUM_RUN_LSB   = 4;
    localparam int STROBE_BIT    = 12;
    localparam int RSV_LSB       = 13;

    localparam logic [CREG_W-1:0] RST_CFG  = 8'h00;
    localparam logic [CREG_W-1:0] RST_CTRL = 8'h00;
    localparam logic [REG_W-1:0]  RST_WORD = 16'h0000;

    // ==========================================================
    // Types
    typedef struct packed {
        logic                  strobe;
        logic [DATA_LANES-1:0] data;
    } lpc_lane_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } lpc_reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } lpc_state_t;

endpackage

`default_nettype wire

/* File: logic/lpc_pattern_mem.sv */
// Expected-pattern memory: one write port, several registered read ports.
// Assumes all ports share clk_sys.
`timescale 1ns/1ns
`default_nettype none

module lpc_pattern_mem
    import lpc_pkg::*;
#(
    parameter int DEPTH  = FRAME_LEN,
    parameter int WIDTH  = REG_W,
    parameter int AW     = POS_W,
    parameter int NREAD  = RD_PORTS
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read ports
    input  wire logic [AW-1:0]    rd_addr [NREAD],
    output var  logic [WIDTH-1:0] rd_data [NREAD]
);

    logic [WIDTH-1:0] mem_r   [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = (wr_en && wr_addr == AW'(i)) ? wr_data : mem_r[i];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            mem_r <= mem_nxt;
        end
    end

    // ==========================================================
    // Read ports
    for (genvar p = 0; p < NREAD; p++) begin : g_rd
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                rd_data[p] <= '0;
            end else begin
                rd_data[p] <= mem_r[rd_addr[p]];
            end
        end
    end

endmodule

`default_nettype wire

/* File: logic/lpc_checker_top.sv */
// LVDS lane pattern checker: frames the received banks, compares them with
// the expected pattern memory and keeps per-bank failure status.
// Assumes the link clock and lanes are asynchronous and far slower than clk_sys.
//
// Summary of operation
// - Per-bank enable bits gate checking on configured banks.
// - Any enable bit blocks data to converter.
// - Strobe lock stops realignment, alarms still raised.
// - Continuous bit zero halts bank at first mismatch.
// - Trigger rise clears failures, starts at frame.
// - Writing trigger zero stops any running test.
// - Running field shows active test per bank.
// - Summary bit set when bank has failures.
// - Summary clears only when all failures cleared.
// - Eight sixteen-bit expected words, value in 12:0.
// - Lowest pattern address is first frame sample.
// - Word bit 12 strobe, bits 11:0 data.
// - Per-bank write-one-to-clear failure fields.
`timescale 1ns/1ns
`default_nettype none

module lpc_checker_top
    import lpc_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // Configuration port
    input  wire lpc_reg_req_t              reg_req,
    output var  logic [REG_W-1:0]          reg_rdata,
    output var  logic                      reg_rvalid,
    // Bank state from the interface setup
    input  wire logic [NUM_BANKS-1:0]      bank_configured,
    // LVDS link
    input  wire logic                      lvds_clk,
    input  wire lpc_lane_t [NUM_BANKS-1:0] lvds_lane,
    // Converter side
    output var  lpc_lane_t [NUM_BANKS-1:0] conv_sample,
    output var  logic                      conv_valid,
    output var  logic [NUM_BANKS-1:0]      strobe_align_alarm
);

    function automatic logic in_range(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] base,
                                      logic [ADDR_W-1:0] span);
        in_range = (a >= base) && (a < base + span);
    endfunction

    function automatic logic [POS_W-1:0] next_pos(logic [POS_W-1:0] p);
        next_pos = (p == POS_W'(FRAME_LEN - 1)) ? '0 : p + 1'b1;
    endfunction

    // ==========================================================
    // Synchronisers
    logic                      lclk_meta_r;
    logic                      lclk_sync_r;
    logic                      lclk_dly_r;
    lpc_lane_t [NUM_BANKS-1:0] lane_meta_r;
    lpc_lane_t [NUM_BANKS-1:0] lane_sync_r;
    logic                      link_edge;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lclk_meta_r <= 1'b0;
            lclk_sync_r <= 1'b0;
            lclk_dly_r  <= 1'b0;
            lane_meta_r <= '0;
            lane_sync_r <= '0;
        end else begin
            lclk_meta_r <= lvds_clk;
            lclk_sync_r <= lclk_meta_r;
            lclk_dly_r  <= lclk_sync_r;
            lane_meta_r <= lvds_lane;
            lane_sync_r <= lane_meta_r;
        end
    end

    // Both link edges carry a sample, so either transition marks one.
    assign link_edge = lclk_sync_r ^ lclk_dly_r;

    // ==========================================================
    // Register state
    logic [CREG_W-1:0]    cfg_r;
    logic [CREG_W-1:0]    cfg_nxt;
    logic [CREG_W-1:0]    ctrl_r;
    logic [CREG_W-1:0]    ctrl_nxt;
    lpc_state_t           state_r;
    lpc_state_t           state_nxt;
    logic [NUM_BANKS-1:0] pending_r;
    logic [NUM_BANKS-1:0] pending_nxt;
    logic [NUM_BANKS-1:0] running_r;
    logic [NUM_BANKS-1:0] running_nxt;
    logic [SAMPLE_W-1:0]  fail_r     [NUM_BANKS];
    logic [SAMPLE_W-1:0]  fail_nxt   [NUM_BANKS];
    logic [RSV_W-1:0]     rsv_r      [NUM_BANKS];
    logic [RSV_W-1:0]     rsv_nxt    [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_en;
    logic                 ctrl_wr;
    logic                 trig_start;
    logic                 pat_wr;

    // ==========================================================
    // Framing and compare pipeline state
    logic [POS_W-1:0]          pos_r     [NUM_BANKS];
    logic [POS_W-1:0]          pos_nxt   [NUM_BANKS];
    logic [POS_W-1:0]          cur_pos   [NUM_BANKS];
    logic [POS_W-1:0]          s1_pos_r  [NUM_BANKS];
    logic [POS_W-1:0]          s1_pos_nxt[NUM_BANKS];
    logic [NUM_BANKS-1:0]      strb_rise;
    logic [NUM_BANKS-1:0]      strb_prev_r;
    logic [NUM_BANKS-1:0]      strb_prev_nxt;
    logic [NUM_BANKS-1:0]      alarm_nxt;
    lpc_lane_t [NUM_BANKS-1:0] s1_samp_r;
    lpc_lane_t [NUM_BANKS-1:0] s1_samp_nxt;
    logic                      s1_vld_r;
    logic                      cmp_vld_r;
    lpc_lane_t [NUM_BANKS-1:0] conv_nxt;
    logic [SAMPLE_W-1:0]       miss      [NUM_BANKS];
    logic [POS_W-1:0]          mem_raddr [RD_PORTS];
    logic [REG_W-1:0]          mem_rdata [RD_PORTS];

    assign bank_en    = cfg_r[CFG_EN_LSB +: NUM_BANKS] & bank_configured;
    assign ctrl_wr    = reg_req.wr && reg_req.addr == ADDR_CTRL;
    assign trig_start = ctrl_wr && reg_req.wdata[CTRL_TRIG_BIT] && !ctrl_r[CTRL_TRIG_BIT];
    assign pat_wr     = reg_req.wr && in_range(reg_req.addr, ADDR_PAT_BASE, PAT_SPAN);

    always_comb begin
        strb_prev_nxt = strb_prev_r;
        alarm_nxt     = '0;
        s1_samp_nxt   = s1_samp_r;
        for (int b = 0; b < NUM_BANKS; b++) begin
            strb_rise[b]  = lane_sync_r[b].strobe && !strb_prev_r[b];
            // With the lock set the strobe may carry test data, so it only alarms.
            cur_pos[b]    = (strb_rise[b] && !cfg_r[CFG_LOCK_BIT]) ? '0 : pos_r[b];
            pos_nxt[b]    = pos_r[b];
            s1_pos_nxt[b] = s1_pos_r[b];
            if (link_edge) begin
                pos_nxt[b]       = next_pos(cur_pos[b]);
                s1_pos_nxt[b]    = cur_pos[b];
                s1_samp_nxt[b]   = lane_sync_r[b];
                strb_prev_nxt[b] = lane_sync_r[b].strobe;
                alarm_nxt[b]     = strb_rise[b] && pos_r[b] != '0;
            end
            mem_raddr[b] = s1_pos_r[b];
            miss[b]      = cmp_vld_r ? (s1_samp_r[b] ^ mem_rdata[b][SAMPLE_W-1:0]) : '0;
            conv_nxt[b]  = (cfg_r[CFG_EN_LSB +: NUM_BANKS] != '0) ? '0 : s1_samp_r[b];
        end
        mem_raddr[NUM_BANKS] = reg_req.addr[WORD_SEL_LSB +: POS_W];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                pos_r[b]    <= '0;
                s1_pos_r[b] <= '0;
            end
            strb_prev_r        <= '0;
            strobe_align_alarm <= '0;
            s1_samp_r          <= '0;
            s1_vld_r           <= 1'b0;
            cmp_vld_r          <= 1'b0;
            conv_sample        <= '0;
            conv_valid         <= 1'b0;
        end else begin
            pos_r              <= pos_nxt;
            s1_pos_r           <= s1_pos_nxt;
            strb_prev_r        <= strb_prev_nxt;
            strobe_align_alarm <= alarm_nxt;
            s1_samp_r          <= s1_samp_nxt;
            s1_vld_r           <= link_edge;
            cmp_vld_r          <= s1_vld_r;
            if (s1_vld_r) begin
                conv_sample <= conv_nxt;
            end
            conv_valid <= s1_vld_r && cfg_r[CFG_EN_LSB +: NUM_BANKS] == '0;
        end
    end

    lpc_pattern_mem #(
        .DEPTH (FRAME_LEN),
        .WIDTH (REG_W),
        .AW    (POS_W),
        .NREAD (RD_PORTS)
    ) u_pattern_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (pat_wr),
        .wr_addr (reg_req.addr[WORD_SEL_LSB +: POS_W]),
        .wr_data (reg_req.wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // ==========================================================
    // Control and status
    always_comb begin
        cfg_nxt     = cfg_r;
        ctrl_nxt    = ctrl_r;
        state_nxt   = state_r;
        pending_nxt = pending_r;
        running_nxt = running_r & bank_en;
        rsv_nxt     = rsv_r;
        fail_nxt    = fail_r;
        if (reg_req.wr && reg_req.addr == ADDR_CFG) begin
            cfg_nxt = reg_req.wdata[CREG_W-1:0];
        end
        if (ctrl_wr) begin
            ctrl_nxt = reg_req.wdata[CREG_W-1:0];
        end
        case (state_r)
            ST_IDLE: begin
                if (trig_start) begin
                    state_nxt   = ST_ARMED;
                    pending_nxt = bank_en;
                end
            end
            ST_ARMED, ST_RUN: begin
                for (int b = 0; b < NUM_BANKS; b++) begin
                    if (link_edge && pending_r[b] && cur_pos[b] == '0) begin
                        pending_nxt[b] = 1'b0;
                        running_nxt[b] = bank_en[b];
                    end
                end
                if (pending_nxt == '0) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (cmp_vld_r && running_r[b] && miss[b] != '0 && !cfg_r[CFG_CONT_BIT]) begin
                running_nxt[b] = 1'b0;
            end
            if (trig_start) begin
                fail_nxt[b] = '0;
            end
            if (reg_req.wr && in_range(reg_req.addr, ADDR_STAT_BASE, STAT_SPAN) &&
                reg_req.addr[WORD_SEL_LSB +: BANK_W] == BANK_W'(b)) begin
                fail_nxt[b] = fail_r[b] & ~reg_req.wdata[SAMPLE_W-1:0];
                rsv_nxt[b]  = reg_req.wdata[RSV_LSB +: RSV_W];
            end
            // The set is applied last so a mismatch beats a clear in the same cycle.
            if (running_r[b]) begin
                fail_nxt[b] = fail_nxt[b] | miss[b];
            end
        end
        if (ctrl_wr && !reg_req.wdata[CTRL_TRIG_BIT]) begin
            state_nxt   = ST_IDLE;
            pending_nxt = '0;
            running_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r     <= RST_CFG;
            ctrl_r    <= RST_CTRL;
            state_r   <= ST_IDLE;
            pending_r <= '0;
            running_r <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                fail_r[b] <= '0;
                rsv_r[b]  <= '0;
            end
        end else begin
            cfg_r     <= cfg_nxt;
            ctrl_r    <= ctrl_nxt;
            state_r   <= state_nxt;
            pending_r <= pending_nxt;
            running_r <= running_nxt;
            fail_r    <= fail_nxt;
            rsv_r     <= rsv_nxt;
        end
    end

    // ==========================================================
    // Read path: two cycles so pattern words come from the registered memory port.
    logic              rd_pend_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [REG_W-1:0]  rdata_nxt;
    logic [NUM_BANKS-1:0] fail_sum;

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            fail_sum[b] = fail_r[b] != '0;
        end
        rdata_nxt = '0;
        if (rd_addr_r == ADDR_CFG) begin
            rdata_nxt = {{(REG_W-CREG_W){1'b0}}, cfg_r};
        end else if (rd_addr_r == ADDR_CTRL) begin
            rdata_nxt = {{(REG_W-CREG_W){1'b0}}, ctrl_r};
        end else if (rd_addr_r == ADDR_SUM) begin
            rdata_nxt[SUM_RUN_LSB +: NUM_BANKS] = running_r;
            rdata_nxt[NUM_BANKS-1:0]            = fail_sum;
        end else if (in_range(rd_addr_r, ADDR_PAT_BASE, PAT_SPAN)) begin
            rdata_nxt = mem_rdata[NUM_BANKS];
        end else if (in_range(rd_addr_r, ADDR_STAT_BASE, STAT_SPAN)) begin
            rdata_nxt = {rsv_r[rd_addr_r[WORD_SEL_LSB +: BANK_W]],
                         fail_r[rd_addr_r[WORD_SEL_LSB +: BANK_W]]};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r  <= 1'b0;
            rd_addr_r  <= '0;
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            rd_pend_r  <= reg_req.rd;
            rd_addr_r  <= reg_req.addr;
            reg_rvalid <= rd_pend_r;
            if (rd_pend_r) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Banks 1 and 2 are watched where the scenarios provoke mismatches; bank 0 is watched for the frame-aligned start.
    a_block_output: assert property (
        conv_valid |-> $past(cfg_r[CFG_EN_LSB +: NUM_BANKS]) == '0)
        else $error("converter data passed while checking enabled");
    a_enable_gates: assert property ((running_r & ~$past(bank_en)) == '0)
        else $error("bank running without enable");
    a_lock_norealign: assert property (
        (link_edge && strb_rise[1] && cfg_r[CFG_LOCK_BIT])
        |=> pos_r[1] == next_pos($past(pos_r[1])))
        else $error("strobe realigned while locked");
    a_halt_first: assert property (
        (cmp_vld_r && running_r[2] && miss[2] != '0 && !cfg_r[CFG_CONT_BIT])
        |=> !running_r[2])
        else $error("bank kept running after mismatch");
    a_cont_keeps: assert property (
        (cfg_r[CFG_CONT_BIT] && running_r[1] && !ctrl_wr && bank_en[1]) |=> running_r[1])
        else $error("continuous run halted");
    a_trig_clear: assert property ((trig_start && !cmp_vld_r) |=> fail_r[1] == '0)
        else $error("trigger did not clear failures");
    a_start_frame: assert property (
        $rose(running_r[0]) |-> $past(link_edge && cur_pos[0] == '0))
        else $error("test started off frame boundary");
    a_trig_stop: assert property (
        (ctrl_wr && !reg_req.wdata[CTRL_TRIG_BIT]) |=> running_r == '0 && state_r == ST_IDLE)
        else $error("trigger zero did not stop test");
    a_run_field: assert property (
        (reg_req.rd && reg_req.addr == ADDR_SUM) |-> ##2
        (reg_rvalid && reg_rdata[SUM_RUN_LSB +: NUM_BANKS] == $past(running_r)))
        else $error("running field wrong");
    a_summary: assert property (
        (reg_req.rd && reg_req.addr == ADDR_SUM) |-> ##2
        reg_rdata[2] == ($past(fail_r[2]) != '0))
        else $error("failure summary wrong");
    a_record_miss: assert property (
        (cmp_vld_r && running_r[2]) |=> (fail_r[2] & $past(miss[2])) == $past(miss[2]))
        else $error("mismatch not recorded");

endmodule

`default_nettype wire

/* File: testbench/lpc_link_src.sv */
// Far-side source of the LVDS link: sends eight-sample frames on all banks.
// Assumes the bench supplies the expected frame and calls send_frames.
`timescale 1ns/1ns
`default_nettype none

module lpc_link_src
    import lpc_pkg::*;
(
    // Expected frame
    input  wire logic [SAMPLE_W-1:0]       pat [FRAME_LEN],
    // LVDS link
    output var  logic                      lvds_clk,
    output var  lpc_lane_t [NUM_BANKS-1:0] lvds_lane
);
    initial begin
        lvds_clk = 1'b0;
        lvds_lane = '0;
    end

    // ==========================================================
    // Frames
    // The clock stands still between bursts and the lanes show the inverse
    // of their last value, so stale data cannot pass for a good sample.
    task automatic send_frames(input int n, input int epos,
                               input logic [SAMPLE_W-1:0] emask,
                               input logic [NUM_BANKS-1:0] ebanks);
        for (int f = 0; f < n; f++) begin
            for (int p = 0; p < FRAME_LEN; p++) begin
                for (int b = 0; b < NUM_BANKS; b++) begin
                    lvds_lane[b] = pat[p] ^ ((p == epos && ebanks[b]) ? emask : '0);
                end
                #20 lvds_clk = ~lvds_clk;
                #20;
            end
        end
        lvds_lane = ~lvds_lane;
    endtask
endmodule

`default_nettype wire

/* File: testbench/lpc_checker_top_bench.sv */
// Self-checking bench of the LVDS lane pattern checker.
// Assumes the link source model drives the far side of the LVDS banks.
`timescale 1ns/1ns
`default_nettype none

module lpc_checker_top_bench;
    import lpc_pkg::*;

    logic                      clk_sys = 1'b0;
    logic                      rst_n;
    lpc_reg_req_t              reg_req;
    logic [REG_W-1:0]          reg_rdata;
    logic                      reg_rvalid;
    logic [NUM_BANKS-1:0]      bank_configured;
    logic                      lvds_clk;
    lpc_lane_t [NUM_BANKS-1:0] lvds_lane;
    lpc_lane_t [NUM_BANKS-1:0] conv_sample;
    logic                      conv_valid;
    logic [NUM_BANKS-1:0]      strobe_align_alarm;
    logic [SAMPLE_W-1:0]       pat [FRAME_LEN];
    logic [REG_W-1:0]          exp_q [$];
    logic [REG_W-1:0]          ex;
    logic [SAMPLE_W-1:0]       samp_q [$];
    logic [SAMPLE_W-1:0]       es;
    logic [NUM_BANKS-1:0]      en_now = '0;
    logic [31:0]               seed = 32'h0000_005e;
    int                        errors = 0;
    int                        tests_run = 0;
    int                        valid_cnt = 0;
    int                        alarm1 = 0;
    int                        cyc = 0;

    always #2 clk_sys = ~clk_sys;

    lpc_checker_top u_lpc_checker_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .bank_configured(bank_configured),
        .lvds_clk(lvds_clk), .lvds_lane(lvds_lane), .conv_sample(conv_sample),
        .conv_valid(conv_valid), .strobe_align_alarm(strobe_align_alarm)
    );
    lpc_link_src u_lpc_link_src (.pat(pat), .lvds_clk(lvds_clk), .lvds_lane(lvds_lane));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic fail(input string m);
        errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask

    task automatic check(input int got, input int exp, input string m);
        tests_run++;
        if (got != exp) fail(m);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One request, held across one rising edge, then released.
    task automatic reg_op(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [REG_W-1:0] d);
        @(negedge clk_sys);
        reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge clk_sys);
        reg_req = '0;
        @(posedge clk_sys);
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
        exp_q.push_back(e);
        reg_op(1'b0, a, 16'h0000);
    endtask

    // Long enough for sync, framing and the failure update to land.
    task automatic settle();
        repeat (12) @(negedge clk_sys);
    endtask

    // ==========================================================
    // Output watcher
    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) fail("read answer without request");
            else begin
                ex = exp_q.pop_front();
                tests_run++;
                if (reg_rdata !== ex) fail("register read");
            end
        end
        if (conv_valid === 1'b1) begin
            valid_cnt++;
            if (en_now != 0) fail("data passed while checking");
            else if (samp_q.size() == 0) fail("sample without note");
            else begin
                es = samp_q.pop_front();
                tests_run++;
                if (conv_sample !== {NUM_BANKS{es}}) fail("converter sample");
            end
        end
        if (strobe_align_alarm[1] === 1'b1) alarm1++;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail("timeout");
            complete_run();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        reg_req = '0;
        rst_n = 1'b0;
        bank_configured = 4'h7;
        for (int p = 0; p < FRAME_LEN; p++) begin
            ex = 16'(xs());
            pat[p] = {(p == 0), ex[11:0]};
        end
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        reg_read(ADDR_CFG, 16'h0000);
        reg_read(ADDR_CTRL, 16'h0000);
        reg_read(ADDR_SUM, 16'h0000);
        reg_read(ADDR_STAT_BASE + 12'h006, 16'h0000);
        reg_read(12'h000, 16'h0000);
        $display("test reset values done");
        for (int p = 0; p < FRAME_LEN; p++) begin
            reg_op(1'b1, ADDR_PAT_BASE + 12'(2 * p), {3'h5, pat[p]});
            reg_read(ADDR_PAT_BASE + 12'(2 * p), {3'h5, pat[p]});
        end
        $display("test pattern memory done");
        reg_op(1'b1, ADDR_CFG, 16'h00f0);
        en_now = 4'hf;
        reg_op(1'b1, ADDR_CTRL, 16'h0001);
        u_lpc_link_src.send_frames(2, 0, '0, '0);
        settle();
        reg_read(ADDR_SUM, 16'h0070);
        u_lpc_link_src.send_frames(1, 3, 13'h0005, 4'hc);
        settle();
        reg_read(ADDR_STAT_BASE + 12'h004, 16'h0005);
        reg_read(ADDR_STAT_BASE + 12'h006, 16'h0000);
        reg_read(ADDR_CTRL, 16'h0001);
        reg_read(ADDR_SUM, 16'h0034);
        u_lpc_link_src.send_frames(1, 6, 13'h00a0, 4'h4);
        settle();
        reg_read(ADDR_STAT_BASE + 12'h004, 16'h0005);
        $display("test halt on error done");
        reg_op(1'b1, ADDR_STAT_BASE + 12'h004, 16'h0001);
        reg_read(ADDR_STAT_BASE + 12'h004, 16'h0004);
        reg_read(ADDR_SUM, 16'h0034);
        reg_op(1'b1, ADDR_STAT_BASE + 12'h004, 16'h0004);
        reg_read(ADDR_SUM, 16'h0030);
        reg_op(1'b1, ADDR_CTRL, 16'h0000);
        reg_read(ADDR_SUM, 16'h0000);
        $display("test clear and stop done");
        reg_op(1'b1, ADDR_CFG, 16'h00f3);
        reg_op(1'b1, ADDR_CTRL, 16'h0001);
        alarm1 = 0;
        u_lpc_link_src.send_frames(2, 5, 13'h1000, 4'h2);
        settle();
        reg_read(ADDR_STAT_BASE + 12'h002, 16'h1000);
        reg_read(ADDR_SUM, 16'h0072);
        check(alarm1, 2, "strobe alarm count");
        reg_op(1'b1, ADDR_CTRL, 16'h0000);
        reg_op(1'b1, ADDR_CTRL, 16'h0001);
        reg_read(ADDR_STAT_BASE + 12'h002, 16'h0000);
        $display("test continuous with lock done");
        reg_op(1'b1, ADDR_CTRL, 16'h0000);
        reg_op(1'b1, ADDR_CFG, 16'h0000);
        en_now = '0;
        valid_cnt = 0;
        for (int p = 0; p < FRAME_LEN; p++) begin
            samp_q.push_back(pat[p]);
        end
        u_lpc_link_src.send_frames(1, 0, '0, '0);
        settle();
        check(valid_cnt, FRAME_LEN, "samples passed when idle");
        $display("test pass through done");
        check(exp_q.size() + samp_q.size(), 0, "missing answers");
        complete_run();
    end
endmodule

`default_nettype wire
